// [rbsc_ctrl.sv]
// reset sequencing and external bus strobe control
`timescale 1ns/1ns
`default_nettype none
module rbsc_ctrl #(
	parameter int unsigned ADDR_W = rbsc_pkg::ADDR_W,
	parameter int unsigned DATA_W = rbsc_pkg::DATA_W
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst_b,
	// external reset pin, asynchronous
	input wire logic reset_input_n,
	// core requests, one access per cycle
	input wire logic [1:0] core_strobe_sel,
	input wire logic core_branch,
	input wire logic [ADDR_W-1:0] core_branch_addr,
	input wire logic [ADDR_W-1:0] core_data_addr,
	input wire logic [DATA_W-1:0] core_wr_data,
	// core status
	output logic core_run,
	output logic [ADDR_W-1:0] program_counter,
	// external bus
	output logic [ADDR_W-1:0] address_bus_out,
	output logic program_mem_strobe_n,
	output logic data_port_strobe_n,
	output logic write_strobe_n,
	output logic [DATA_W-1:0] data_bus_o,
	output logic data_bus_oe
);
	// refused at elaboration: the zero and data constants are sized for these widths
	if (ADDR_W < 1 || ADDR_W > 16 || DATA_W != 16) begin : g_bad_width
		$error("rbsc_ctrl: unsupported width");
	end

	typedef enum logic [1:0] {RBSC_RESET, RBSC_RESUME, RBSC_RUN} rbsc_state_e;

	// synchroniser, first stage read only by second
	logic sync1_reg;
	logic sync2_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= reset_input_n;
			sync2_reg <= sync1_reg;
		end
	end
	wire logic in_reset = !sync2_reg;

	rbsc_state_e state_reg, state_next;
	logic [ADDR_W-1:0] pc_reg, pc_next;
	logic [ADDR_W-1:0] ab_reg, ab_next;
	logic pm_reg, pm_next, dp_reg, dp_next, we_reg, we_next;
	logic [DATA_W-1:0] dout_reg, dout_next;
	logic oe_reg, oe_next;

	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		ab_next = ab_reg;
		pm_next = rbsc_pkg::STROBE_IDLE;
		dp_next = rbsc_pkg::STROBE_IDLE;
		we_next = rbsc_pkg::STROBE_IDLE;
		dout_next = dout_reg;
		oe_next = 1'b0;
		unique case (state_reg)
			RBSC_RESET: begin
				// strobes idle, bus floats, counter and address cleared
				pc_next = ADDR_W'(rbsc_pkg::ADDR_ZERO);
				ab_next = ADDR_W'(rbsc_pkg::ADDR_ZERO);
				if (!in_reset) begin
					state_next = RBSC_RESUME;
				end
			end
			RBSC_RESUME: begin
				// one full cycle with address zero before the first fetch
				if (in_reset) begin
					state_next = RBSC_RESET;
				end else begin
					state_next = RBSC_RUN;
				end
			end
			RBSC_RUN: begin
				if (in_reset) begin
					// entry latency depends on pin phase; any write is cut short
					state_next = RBSC_RESET;
				end else begin
					// single select code, so strobes are exclusive
					unique case (core_strobe_sel)
						rbsc_pkg::STROBE_PMEM: begin
							pm_next = rbsc_pkg::STROBE_ACTIVE;
							ab_next = pc_reg;
							pc_next = core_branch ? core_branch_addr : pc_reg + ADDR_W'(1);
						end
						rbsc_pkg::STROBE_PORT: begin
							dp_next = rbsc_pkg::STROBE_ACTIVE;
							ab_next = core_data_addr;
						end
						rbsc_pkg::STROBE_WRITE: begin
							we_next = rbsc_pkg::STROBE_ACTIVE;
							ab_next = core_data_addr;
							dout_next = core_wr_data;
							oe_next = 1'b1;
						end
						rbsc_pkg::STROBE_NONE: begin
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= RBSC_RESET;
			pc_reg <= ADDR_W'(rbsc_pkg::ADDR_ZERO);
			ab_reg <= ADDR_W'(rbsc_pkg::ADDR_ZERO);
			pm_reg <= rbsc_pkg::STROBE_IDLE;
			dp_reg <= rbsc_pkg::STROBE_IDLE;
			we_reg <= rbsc_pkg::STROBE_IDLE;
			dout_reg <= rbsc_pkg::DATA_ZERO;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			ab_reg <= ab_next;
			pm_reg <= pm_next;
			dp_reg <= dp_next;
			we_reg <= we_next;
			dout_reg <= dout_next;
			oe_reg <= oe_next;
		end
	end

	assign core_run = (state_reg == RBSC_RUN);
	assign program_counter = pc_reg;
	assign address_bus_out = ab_reg;
	assign program_mem_strobe_n = pm_reg;
	assign data_port_strobe_n = dp_reg;
	assign write_strobe_n = we_reg;
	assign data_bus_o = dout_reg;
	assign data_bus_oe = oe_reg;

	// reset seen on the synchronised level
	sequence s_reset_seen;
		in_reset;
	endsequence
	sequence s_quiet_bus;
		program_mem_strobe_n && data_port_strobe_n && write_strobe_n && !data_bus_oe;
	endsequence

	property p_reset_quiet;
		@(posedge clk) disable iff (!rst_b) s_reset_seen |=> s_quiet_bus;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("bus active in reset");

	property p_clear_zero;
		@(posedge clk) disable iff (!rst_b)
			in_reset ##1 in_reset |=> (program_counter == '0 && address_bus_out == '0);
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("pc or address not cleared");

	property p_resume;
		@(posedge clk) disable iff (!rst_b)
			(state_reg == RBSC_RESET && !in_reset) ##1 !in_reset |=> core_run;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume after reset release");

	property p_resume_delay;
		@(posedge clk) disable iff (!rst_b) $rose(core_run) |-> $past(state_reg) == RBSC_RESUME;
	endproperty
	a_resume_delay: assert property (p_resume_delay) else $error("resumed too early");

	property p_onehot;
		@(posedge clk) disable iff (!rst_b)
			$onehot0({!program_mem_strobe_n, !data_port_strobe_n, !write_strobe_n});
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one strobe active");

	property p_oe_with_write;
		@(posedge clk) disable iff (!rst_b) data_bus_oe == !write_strobe_n;
	endproperty
	a_oe_with_write: assert property (p_oe_with_write) else $error("data bus drive mismatch");

	property p_sync_latency;
		@(posedge clk) disable iff (!rst_b)
			$fell(reset_input_n) ##1 !reset_input_n |=> ##1 in_reset;
	endproperty
	a_sync_latency: assert property (p_sync_latency) else $error("reset entry too slow");

	property p_first_fetch_zero;
		@(posedge clk) disable iff (!rst_b)
			$rose(core_run) |-> program_counter == '0 && address_bus_out == '0;
	endproperty
	a_first_fetch_zero: assert property (p_first_fetch_zero) else $error("fetch not at zero");

	// a request is taken only in run while the synchronised reset stays released
	sequence s_taking;
		core_run && !in_reset;
	endsequence

	property p_fetch_step;
		@(posedge clk) disable iff (!rst_b)
			s_taking ##0 (core_strobe_sel == rbsc_pkg::STROBE_PMEM && !core_branch)
			|=> program_counter == $past(program_counter) + ADDR_W'(1);
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("pc did not step");

	property p_write_drive;
		@(posedge clk) disable iff (!rst_b)
			s_taking ##0 (core_strobe_sel == rbsc_pkg::STROBE_WRITE)
			|=> !write_strobe_n && data_bus_oe && data_bus_o == $past(core_wr_data);
	endproperty
	a_write_drive: assert property (p_write_drive) else $error("write not driven");

	property p_port_strobe;
		@(posedge clk) disable iff (!rst_b)
			s_taking ##0 (core_strobe_sel == rbsc_pkg::STROBE_PORT)
			|=> !data_port_strobe_n && address_bus_out == $past(core_data_addr);
	endproperty
	a_port_strobe: assert property (p_port_strobe) else $error("port access missing");
endmodule : rbsc_ctrl
`default_nettype wire

// [rbsc_pkg.sv]
// constants for the reset and bus strobe control block
package rbsc_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned SYNC_STAGES = 2;
	localparam logic [11:0] ADDR_ZERO = 12'h000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic STROBE_ACTIVE = 1'b0;
	localparam logic [1:0] STROBE_NONE = 2'h0;
	localparam logic [1:0] STROBE_PMEM = 2'h1;
	localparam logic [1:0] STROBE_PORT = 2'h2;
	localparam logic [1:0] STROBE_WRITE = 2'h3;
endpackage : rbsc_pkg

// [rbsc_mem_model.sv]
// far-side memory and port model answering reads
`timescale 1ns/1ns
`default_nettype none
module rbsc_mem_model (
	// bus from the device
	input wire logic clk,
	input wire logic program_mem_strobe_n,
	input wire logic data_port_strobe_n,
	input wire logic [11:0] address_bus_out,
	// read data toward the device
	output logic [15:0] rd_data
);
	always_ff @(posedge clk) begin
		if (!program_mem_strobe_n || !data_port_strobe_n) begin
			rd_data <= {4'h0, address_bus_out};
		end else begin
			// released bus: invert each cycle, so the last data value comes back every second cycle
			rd_data <= ~rd_data;
		end
	end
endmodule : rbsc_mem_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the reset and bus strobe control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb;
	logic clk, rst_b, reset_input_n, core_branch, core_run, data_bus_oe;
	logic program_mem_strobe_n, data_port_strobe_n, write_strobe_n;
	logic [1:0] core_strobe_sel;
	logic [11:0] core_branch_addr, core_data_addr, program_counter, address_bus_out;
	logic [15:0] core_wr_data, data_bus_o, rd_data;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	rbsc_ctrl dut_u (.clk, .rst_b, .reset_input_n, .core_strobe_sel, .core_branch,
		.core_branch_addr, .core_data_addr, .core_wr_data, .core_run, .program_counter,
		.address_bus_out, .program_mem_strobe_n, .data_port_strobe_n, .write_strobe_n,
		.data_bus_o, .data_bus_oe);
	rbsc_mem_model mem_u (.clk, .program_mem_strobe_n, .data_port_strobe_n,
		.address_bus_out, .rd_data);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// run needs under a hundred cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic bus(input logic pm, input logic dp, input logic wr);
		`CHK(program_mem_strobe_n, pm)
		`CHK(data_port_strobe_n, dp)
		`CHK(write_strobe_n, wr)
		`CHK(data_bus_oe, ~wr)
	endtask : bus
	task automatic pin_reset();
		reset_input_n <= 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		bus(1'b1, 1'b1, 1'b1);
		`CHK(program_counter, 12'h000)
		`CHK(address_bus_out, 12'h000)
		`CHK(core_run, 1'b0)
		@(posedge clk) reset_input_n <= 1'b1;
		core_strobe_sel <= 2'h0;
		for (int i = 0; i < 20 && core_run !== 1'b1; i++) @(negedge clk);
		`CHK(core_run, 1'b1)
	endtask : pin_reset
	task automatic fetch_pair();
		@(posedge clk) core_strobe_sel <= 2'h1;
		@(posedge clk) core_branch <= 1'b1;
		@(negedge clk);
		bus(1'b0, 1'b1, 1'b1);
		`CHK(address_bus_out, 12'h000)
		`CHK(program_counter, 12'h001)
		@(posedge clk) core_strobe_sel <= 2'h0;
		core_branch <= 1'b0;
		@(negedge clk);
		bus(1'b0, 1'b1, 1'b1);
		`CHK(address_bus_out, 12'h001)
		`CHK(program_counter, core_branch_addr)
		@(negedge clk);
		bus(1'b1, 1'b1, 1'b1);
	endtask : fetch_pair
	task automatic access(input logic [1:0] sel, input logic dp, input logic wr);
		@(posedge clk) core_strobe_sel <= sel;
		@(posedge clk) core_strobe_sel <= 2'h0;
		@(negedge clk);
		bus(1'b1, dp, wr);
	endtask : access
	initial begin
		rst_b <= 1'b0;
		reset_input_n <= 1'b1;
		core_strobe_sel <= 2'h0;
		core_branch <= 1'b0;
		core_branch_addr <= 12'h7a5;
		core_data_addr <= 12'h5c3;
		core_wr_data <= 16'hbeef;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		pin_reset();
		fetch_pair();
		access(2'h2, 1'b0, 1'b1);
		@(negedge clk);
		`CHK(rd_data, {4'h0, core_data_addr})
		access(2'h3, 1'b1, 1'b0);
		`CHK(data_bus_o, core_wr_data)
		`CHK(address_bus_out, core_data_addr)
		// writes run until reset cuts them; the address they leave is not judged
		@(posedge clk) core_strobe_sel <= 2'h3;
		pin_reset();
		fetch_pair();
		final_report();
	end
endmodule : tb
`default_nettype wire
